// ---- core/csi_slave_pkg.sv ----
// Constants, register map and carrier types for the clocked serial slave channel
//
// Behaviour
// - The channel moves exactly one frame per transfer, never a continuous stream.
// - Phase type 1: clock idles high, data changes on falling edge, sampled on rising.
// - Every transfer carries exactly 8 bits in each direction.
// - A transfer-end interrupt is raised when each single transfer completes.
// - The serial clock is only an input; the external master alone drives it.
// - The serial data output idles at logic 1 before any transfer.
// - Bit 0 of the output-enable control lets shifted data reach the output line.
// - Writing 1 to start-trigger bit 0 starts the channel into communication standby.
// - A started channel waits in standby until the master's clock edges arrive.
// - Busy goes low only after the next transmit byte has been loaded.
// - On transfer end the received byte is captured, then busy is driven high.
// - Each transfer end makes the received byte readable; software may load the next.
// - Overrun error is reported in bit 0 of the channel status register.
// - At transfer end the shift register moves to the data register, then interrupt rises.
// - Busy only gates the next transfer; it never disturbs a transfer in progress.
package csi_slave_pkg;

	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_START  = 8'h04;
	localparam logic [7:0] OFS_DATA   = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_MASK   = 8'h10;

	localparam int CTRL_OE_BIT    = 0;
	localparam int CTRL_READY_BIT = 1;
	localparam int START_TRIG_BIT = 0;
	localparam int START_STOP_BIT = 1;
	localparam int ST_OVR_BIT     = 0;
	localparam int ST_XFER_BIT    = 1;
	localparam int ST_RXFULL_BIT  = 2;
	localparam int ST_RUN_BIT     = 3;
	localparam int ST_BUSY_BIT    = 4;

	localparam int FRAME_BITS = 8;
	localparam int CNT_W      = 3;
	localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;

	localparam logic [7:0] TX_RST    = 8'hff;
	localparam logic [1:0] STAT_RST  = 2'h0;
	localparam logic [1:0] MASK_RST  = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLV  = 2'h2;

	typedef struct packed {
		logic sck;
		logic si;
	} link_in_s;

	localparam link_in_s LINK_IDLE = 2'h3;

endpackage

// ---- core/link_sync.sv ----
// Two-flop synchroniser for the serial clock and data input pins
`timescale 1ns/1ns
module link_sync
	import csi_slave_pkg::*;
(
	input  wire logic     aclk,    // System clock
	input  wire logic     aresetn, // Synchronous reset, active low
	input  wire link_in_s raw,     // Asynchronous pin levels
	output link_in_s      sync     // Levels in the aclk domain
);
	link_in_s meta_q;
	link_in_s sync_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= LINK_IDLE;
			sync_q <= LINK_IDLE;
		end else begin
			meta_q <= raw;
			sync_q <= meta_q;
		end
	end

	assign sync = sync_q;
endmodule

// ---- core/frame_shifter.sv ----
// Eight-bit phase type 1 shift engine paced by the master's clock edges
`timescale 1ns/1ns
module frame_shifter
	import csi_slave_pkg::*;
(
	input  wire logic       aclk,     // System clock
	input  wire logic       aresetn,  // Synchronous reset, active low
	input  wire logic       run,      // Channel started
	input  wire logic       sck_fall, // Falling edge of serial clock seen
	input  wire logic       sck_rise, // Rising edge of serial clock seen
	input  wire logic       si,       // Synchronised serial data in
	input  wire logic [7:0] tx_byte,  // Byte to send in next frame
	output logic            so,       // Serial bit out
	output logic            done,     // One-cycle pulse at frame end
	output logic      [7:0] rx_byte   // Last byte received
);
	logic [7:0]       txsh_q;
	logic [7:0]       rxsh_q;
	logic [7:0]       rx_q;
	logic [CNT_W-1:0] cnt_q;
	logic             so_q;
	logic             done_q;

	wire first_bit = (cnt_q == '0);
	wire last_rise = run && sck_rise && (cnt_q == CNT_LAST);

	////////////////////////////////////////////////////////////////////////////
	// Data driven out on falling edge, sampled on rising edge, MSB first
	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			txsh_q <= TX_RST;
			so_q   <= 1'b1;
			cnt_q  <= '0;
		end else begin
			if (sck_fall) begin
				so_q   <= first_bit ? tx_byte[7] : txsh_q[7];
				txsh_q <= first_bit ? {tx_byte[6:0], 1'b0} : {txsh_q[6:0], 1'b0};
			end
			if (sck_rise) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// Capture at the eighth rising edge; the frame ends there
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxsh_q <= 8'h00;
			rx_q   <= 8'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= last_rise;
			if (run && sck_rise) begin
				rxsh_q <= {rxsh_q[6:0], si};
			end
			if (last_rise) begin
				rx_q <= {rxsh_q[6:0], si};
			end
		end
	end

	assign so      = so_q;
	assign done    = done_q;
	assign rx_byte = rx_q;

	////////////////////////////////////////////////////////////////////////////
	property p_frame_len;
		@(posedge aclk) disable iff (!aresetn)
		done |-> ($past(cnt_q) == CNT_LAST) && $past(sck_rise);
	endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame ended before eight bits");

	property p_standby;
		@(posedge aclk) disable iff (!aresetn)
		run && !sck_fall && !sck_rise |=> $stable(cnt_q) && $stable(so_q) && !done;
	endproperty
	a_standby: assert property (p_standby) else $error("shifter moved without clock edges");

	property p_phase;
		@(posedge aclk) disable iff (!aresetn)
		run && sck_fall && !first_bit |=> so_q == $past(txsh_q[7]);
	endproperty
	a_phase: assert property (p_phase) else $error("output bit not shifted on falling edge");
endmodule

// ---- core/csi_slave.sv ----
// Clocked serial slave channel with busy handshake and AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module csi_slave
	import csi_slave_pkg::*;
(
	input  wire logic       aclk,             // System clock, 100 MHz
	input  wire logic       aresetn,          // Synchronous reset, active low
	input  wire logic [7:0] s_axi_awaddr,     // Write address
	input  wire logic       s_axi_awvalid,    // Write address valid
	output logic            s_axi_awready,    // Write address ready
	input  wire logic [31:0] s_axi_wdata,     // Write data
	input  wire logic [3:0] s_axi_wstrb,      // Write byte strobes
	input  wire logic       s_axi_wvalid,     // Write data valid
	output logic            s_axi_wready,     // Write data ready
	output logic [1:0]      s_axi_bresp,      // Write response
	output logic            s_axi_bvalid,     // Write response valid
	input  wire logic       s_axi_bready,     // Write response ready
	input  wire logic [7:0] s_axi_araddr,     // Read address
	input  wire logic       s_axi_arvalid,    // Read address valid
	output logic            s_axi_arready,    // Read address ready
	output logic [31:0]     s_axi_rdata,      // Read data
	output logic [1:0]      s_axi_rresp,      // Read response
	output logic            s_axi_rvalid,     // Read data valid
	input  wire logic       s_axi_rready,     // Read data ready
	input  wire logic       serial_clock_in,  // Serial clock from master
	input  wire logic       serial_data_in,   // Serial data from master
	output logic            serial_data_out,  // Serial data to master
	output logic            busy_out,         // High while not ready
	output logic            transfer_end_irq  // Level interrupt
);
	////////////////////////////////////////////////////////////////////////////
	// Link side
	link_in_s   pins;
	link_in_s   link;
	logic       sck_prev_q;
	logic       sh_so;
	logic       done;
	logic [7:0] rx_byte;

	assign pins.sck = serial_clock_in;
	assign pins.si  = serial_data_in;

	link_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.raw     (pins),
		.sync    (link)
	);

	wire sck_fall = sck_prev_q && !link.sck;
	wire sck_rise = !sck_prev_q && link.sck;

	logic       running_q;
	logic [7:0] tx_q;

	// Busy is not an input here, so it cannot disturb a frame in flight
	frame_shifter u_shift (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.run      (running_q),
		.sck_fall (sck_fall),
		.sck_rise (sck_rise),
		.si       (link.si),
		.tx_byte  (tx_q),
		.so       (sh_so),
		.done     (done),
		.rx_byte  (rx_byte)
	);

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	logic        awready_q;
	logic        wready_q;
	logic        bvalid_q;
	logic        aw_hold_q;
	logic        w_hold_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [1:0]  bresp_q;

	wire aw_take = s_axi_awvalid && awready_q;
	wire w_take  = s_axi_wvalid && wready_q;
	wire b_take  = bvalid_q && s_axi_bready;
	wire wr_go   = aw_hold_q && w_hold_q && !bvalid_q;
	wire wr_lo   = wr_go && wstrb_q[0];
	wire wr_hit  = (awaddr_q == OFS_CTRL) || (awaddr_q == OFS_START) || (awaddr_q == OFS_DATA)
		|| (awaddr_q == OFS_STATUS) || (awaddr_q == OFS_MASK);
	wire wr_ctrl   = wr_lo && (awaddr_q == OFS_CTRL);
	wire wr_start  = wr_lo && (awaddr_q == OFS_START);
	wire wr_data   = wr_lo && (awaddr_q == OFS_DATA);
	wire wr_status = wr_lo && (awaddr_q == OFS_STATUS);
	wire wr_mask   = wr_lo && (awaddr_q == OFS_MASK);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				awready_q <= 1'b0;
				aw_hold_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (w_take) begin
				wready_q <= 1'b0;
				w_hold_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLV;
			end
			if (b_take) begin
				bvalid_q  <= 1'b0;
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Channel control and status
	logic       oe_q;
	logic       busy_q;
	logic       tx_loaded_q;
	logic       rx_full_q;
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic       irq_q;
	logic       so_q;
	logic       rd_data_take;

	wire [1:0] st_set = {done, done && rx_full_q};
	wire [1:0] st_clr = wr_status ? {wdata_q[ST_XFER_BIT], wdata_q[ST_OVR_BIT]} : 2'h0;
	wire [1:0] status_d = (status_q & ~st_clr) | st_set;
	wire ready_req = wr_ctrl && wdata_q[CTRL_READY_BIT];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oe_q      <= 1'b0;
			running_q <= 1'b0;
			tx_q      <= TX_RST;
			mask_q    <= MASK_RST;
			status_q  <= STAT_RST;
		end else begin
			status_q <= status_d;
			if (wr_ctrl) begin
				oe_q <= wdata_q[CTRL_OE_BIT];
			end
			if (wr_start && wdata_q[START_TRIG_BIT]) begin
				running_q <= 1'b1;
			end else if (wr_start && wdata_q[START_STOP_BIT]) begin
				running_q <= 1'b0;
			end
			if (wr_data) begin
				tx_q <= wdata_q[7:0];
			end
			if (wr_mask) begin
				mask_q <= {wdata_q[ST_XFER_BIT], wdata_q[ST_OVR_BIT]};
			end
		end
	end

	// Handshake: busy drops only with a byte loaded, rises at every frame end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_q      <= 1'b1;
			tx_loaded_q <= 1'b0;
			rx_full_q   <= 1'b0;
			irq_q       <= 1'b0;
			so_q        <= 1'b1;
		end else begin
			if (done) begin
				busy_q <= 1'b1;
			end else if (ready_req && tx_loaded_q) begin
				busy_q <= 1'b0;
			end
			if (wr_data) begin
				tx_loaded_q <= 1'b1;
			end else if (done) begin
				tx_loaded_q <= 1'b0;
			end
			if (done) begin
				rx_full_q <= 1'b1;
			end else if (rd_data_take) begin
				rx_full_q <= 1'b0;
			end
			irq_q <= |(status_d & mask_q);
			so_q  <= oe_q ? sh_so : 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	logic        arready_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [31:0] rd_mux;
	logic        rd_hit;

	wire ar_take = s_axi_arvalid && arready_q;
	wire r_take  = rvalid_q && s_axi_rready;
	assign rd_data_take = ar_take && (s_axi_araddr == OFS_DATA);

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		if (s_axi_araddr == OFS_CTRL) begin
			rd_mux[CTRL_OE_BIT] = oe_q;
		end else if (s_axi_araddr == OFS_START) begin
			rd_mux[START_TRIG_BIT] = running_q;
		end else if (s_axi_araddr == OFS_DATA) begin
			rd_mux[7:0] = rx_byte;
		end else if (s_axi_araddr == OFS_STATUS) begin
			rd_mux[ST_OVR_BIT]    = status_q[0];
			rd_mux[ST_XFER_BIT]   = status_q[1];
			rd_mux[ST_RXFULL_BIT] = rx_full_q;
			rd_mux[ST_RUN_BIT]    = running_q;
			rd_mux[ST_BUSY_BIT]   = busy_q;
		end else if (s_axi_araddr == OFS_MASK) begin
			rd_mux[ST_OVR_BIT]  = mask_q[0];
			rd_mux[ST_XFER_BIT] = mask_q[1];
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q  <= 1'b1;
			rvalid_q   <= 1'b0;
			rdata_q    <= 32'h0000_0000;
			rresp_q    <= RESP_OKAY;
			sck_prev_q <= 1'b1;
		end else begin
			sck_prev_q <= link.sck;
			if (ar_take) begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rdata_q   <= rd_mux;
				rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLV;
			end else if (r_take) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	assign s_axi_awready    = awready_q;
	assign s_axi_wready     = wready_q;
	assign s_axi_bvalid     = bvalid_q;
	assign s_axi_bresp      = bresp_q;
	assign s_axi_arready    = arready_q;
	assign s_axi_rvalid     = rvalid_q;
	assign s_axi_rdata      = rdata_q;
	assign s_axi_rresp      = rresp_q;
	assign serial_data_out  = so_q;
	assign busy_out         = busy_q;
	assign transfer_end_irq = irq_q;

	////////////////////////////////////////////////////////////////////////////
	property p_oe_gate;
		@(posedge aclk) disable iff (!aresetn)
		!oe_q |=> serial_data_out;
	endproperty
	a_oe_gate: assert property (p_oe_gate) else $error("data out not held high while disabled");

	property p_idle_high;
		@(posedge aclk) disable iff (!aresetn)
		!running_q ##1 !running_q |=> serial_data_out;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("data out not idle high before start");

	property p_end_flag;
		@(posedge aclk) disable iff (!aresetn)
		done |=> status_q[1] && rx_full_q ##1 (transfer_end_irq || !(status_q[1] && $past(mask_q[1])));
	endproperty
	a_end_flag: assert property (p_end_flag) else $error("transfer end not flagged");

	property p_busy_after;
		@(posedge aclk) disable iff (!aresetn)
		done |=> busy_q && (rx_byte == $past(rx_byte));
	endproperty
	a_busy_after: assert property (p_busy_after) else $error("busy not raised at transfer end");

	property p_overrun;
		@(posedge aclk) disable iff (!aresetn)
		done && rx_full_q |=> status_q[0];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_ready_loaded;
		@(posedge aclk) disable iff (!aresetn)
		$fell(busy_q) |-> $past(tx_loaded_q) && $past(ready_req);
	endproperty
	a_ready_loaded: assert property (p_ready_loaded) else $error("busy dropped without a loaded byte");

	property p_start;
		@(posedge aclk) disable iff (!aresetn)
		wr_start && wdata_q[START_TRIG_BIT] |=> running_q ##1 s_axi_bvalid || $past(b_take);
	endproperty
	a_start: assert property (p_start) else $error("start trigger ignored");

	property p_irq_level;
		@(posedge aclk) disable iff (!aresetn)
		|(status_q & mask_q) ##1 |(status_q & mask_q) |-> transfer_end_irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt low with unmasked status set");
endmodule

// ---- verif/link_master.sv ----
// Behavioural serial master for the slave channel: phase type 1, MSB first
`timescale 1ns/1ns
module link_master (
	output logic      sck,  // Serial clock to slave
	output logic      mosi, // Data to slave
	input  wire logic miso, // Data from slave
	input  wire logic busy  // Slave not ready while high
);
	localparam int HALF = 80;

	initial begin
		sck = 1'b1;
		mosi = 1'b1;
	end

	// One frame; ok is low if the slave never became ready
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ok);
		int w;
		w = 0;
		rx = 8'h00;
		while (busy !== 1'b0 && w < 200) begin
			#(HALF);
			w++;
		end
		ok = (busy === 1'b0);
		if (ok) begin
			for (int i = 7; i >= 0; i--) begin
				#(HALF);
				sck = 1'b0;
				mosi = tx[i];
				#(HALF);
				sck = 1'b1;
				rx[i] = miso;
			end
			#(HALF);
			mosi = ~mosi;
		end
	endtask
endmodule

// ---- verif/csi_slave_test.sv ----
// Self-checking bench for the serial slave channel
`timescale 1ns/1ns
module csi_slave_test
	import csi_slave_pkg::*;
;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ok;
	logic [7:0]  awaddr, araddr, mrx;
	logic [31:0] wdata, rd;
	logic [3:0]  wstrb;
	wire         awready, wready, bvalid, arready, rvalid, sck, mosi, miso, busy, irq;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          n_mismatch, compares, cycles;

	csi_slave dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_clock_in(sck),
		.serial_data_in(mosi), .serial_data_out(miso), .busy_out(busy), .transfer_end_irq(irq));

	link_master mst_u (.sck(sck), .mosi(mosi), .miso(miso), .busy(busy));

	always #5 aclk = ~aclk;

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			test_done();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (n_mismatch == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_p, w_p;
		aw_p = 1'b1;
		w_p = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw_p || w_p) begin
			@(posedge aclk);
			if (aw_p && awready === 1'b1) begin
				aw_p = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_p && wready === 1'b1) begin
				w_p = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd_reg(a, RESP_OKAY, rd);
		chk(rd, exp);
	endtask

	// Master sends tx and must receive exp from the slave
	task automatic frame(input logic [7:0] tx, input logic [7:0] exp);
		mst_u.xfer(tx, mrx, ok);
		chk({31'h0, ok}, 32'h1);
		chk({24'h0, mrx}, {24'h0, exp});
		repeat (4) @(posedge aclk);
	endtask

	task automatic load(input logic [7:0] b, input logic [31:0] ctrl);
		wr(OFS_DATA, {24'h0, b}, RESP_OKAY);
		wr(OFS_CTRL, ctrl, RESP_OKAY);
		repeat (2) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		n_mismatch = 0;
		compares = 0;
		cycles = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({31'h0, busy}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		chk({31'h0, miso}, 32'h1);
		rchk(OFS_STATUS, 32'h10);
		rchk(OFS_MASK, 32'h0);
		rd_reg(8'h14, RESP_SLV, rd);
		chk(rd, 32'h0);
		wr(8'h14, 32'h1, RESP_SLV);
		// Ready request with nothing loaded keeps the slave busy
		wr(OFS_CTRL, 32'h3, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({31'h0, busy}, 32'h1);
		rchk(OFS_CTRL, 32'h1);
		load(8'ha5, 32'h3);
		chk({31'h0, busy}, 32'h0);
		wr(OFS_START, 32'h1, RESP_OKAY);
		rchk(OFS_START, 32'h1);
		rchk(OFS_STATUS, 32'h08);
		chk({31'h0, miso}, 32'h1);
		wr(OFS_MASK, 32'h3, RESP_OKAY);
		frame(8'h3c, 8'ha5);
		chk({31'h0, busy}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rchk(OFS_STATUS, 32'h1e);
		rchk(OFS_DATA, 32'h3c);
		rchk(OFS_STATUS, 32'h1a);
		wr(OFS_STATUS, 32'h2, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		// Two frames without reading the first byte
		wr(OFS_MASK, 32'h0, RESP_OKAY);
		load(8'h5a, 32'h3);
		frame(8'h81, 8'h5a);
		load(8'hc3, 32'h3);
		frame(8'h7e, 8'hc3);
		rchk(OFS_STATUS, 32'h1f);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_MASK, 32'h1, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h1);
		rchk(OFS_DATA, 32'h7e);
		wr(OFS_STATUS, 32'h3, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, 32'h0);
		rchk(OFS_STATUS, 32'h18);
		// Output disabled: line stays high through a whole frame
		load(8'h00, 32'h2);
		frame(8'h55, 8'hff);
		rchk(OFS_DATA, 32'h55);
		wr(OFS_START, 32'h2, RESP_OKAY);
		rchk(OFS_STATUS, 32'h12);
		test_done();
	end
endmodule
